// ===== pc_paging_pkg.sv
`default_nettype none

package pc_paging_pkg;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      VARIANT_SINGLE_PAGE,
      VARIANT_FOUR_BANK,
      VARIANT_EIGHT_BANK
   } variant_e;

   typedef enum logic [2:0] {
      OP_HOLD,
      OP_STEP,
      OP_JUMP,
      OP_CALL,
      OP_RETURN,
      OP_WRITE_LOW
   } op_e;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int BUS_ADDR_W    = 11;
   localparam int BUS_DATA_W    = 32;
   localparam int PC_W          = 11;
   localparam int PAGE_W        = 2;
   localparam int PTR_W         = 8;
   localparam int WORD_W        = 8;
   localparam int OPERAND_W     = 9;
   localparam int DATA_IDX_W    = 8;
   localparam int DATA_DEPTH    = 256;
   localparam int DATA_WIN_BIT  = 10;
   localparam int DATA_IDX_LSB  = 2;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [10:0] OFS_POINTER  = 11'h000;
   localparam logic [10:0] OFS_INDIRECT = 11'h004;
   localparam logic [10:0] OFS_PAGE     = 11'h008;
   localparam logic [10:0] OFS_PC       = 11'h00c;
   localparam logic [10:0] OFS_LEVEL1   = 11'h010;
   localparam logic [10:0] OFS_LEVEL2   = 11'h014;
   localparam logic [10:0] OFS_WORK     = 11'h018;

   // ---------------------------------------------------------------
   // Reset values and fixed patterns
   // ---------------------------------------------------------------
   localparam logic [10:0] PC_MASK_SINGLE   = 11'h1ff;
   localparam logic [10:0] PC_MASK_MULTI    = 11'h7ff;
   localparam logic [1:0]  PAGE_RESET       = 2'h0;
   localparam logic [7:0]  POINTER_RESET    = 8'h00;
   localparam logic [7:0]  WORK_RESET       = 8'h00;
   localparam logic [10:0] STACK_RESET      = 11'h000;
   localparam logic [7:0]  DATA_RESET       = 8'h00;
   localparam logic [7:0]  PTR_FORCE_SINGLE = 8'he0;
   localparam logic [7:0]  PTR_FORCE_FOUR   = 8'h80;
   localparam logic [7:0]  INDIRECT_EMPTY   = 8'h00;
   localparam logic [4:0]  OFFSET_ZERO      = 5'h00;

   // ---------------------------------------------------------------
   // Variant helpers
   // ---------------------------------------------------------------
   function automatic logic [10:0] pc_mask(variant_e v);
      return (v == VARIANT_SINGLE_PAGE) ? PC_MASK_SINGLE : PC_MASK_MULTI;
   endfunction

   function automatic logic [7:0] pointer_view(variant_e v,
                                               logic [7:0] raw);
      case (v)
         VARIANT_SINGLE_PAGE: return raw | PTR_FORCE_SINGLE;
         VARIANT_FOUR_BANK:   return raw | PTR_FORCE_FOUR;
         default:             return raw;
      endcase
   endfunction

   function automatic logic [7:0] pointer_index(variant_e v,
                                                logic [7:0] raw);
      case (v)
         VARIANT_SINGLE_PAGE: return {3'h0, raw[4:0]};
         VARIANT_FOUR_BANK:   return {1'h0, raw[6:0]};
         default:             return raw;
      endcase
   endfunction

endpackage

`default_nettype wire

// ===== data_file.sv
`default_nettype none

module data_file
   import pc_paging_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_n_i,
   // Write port
   input  wire logic                  wr_en_i,
   input  wire logic [DATA_IDX_W-1:0] wr_idx_i,
   input  wire logic [WORD_W-1:0]     wr_data_i,
   // Read port
   input  wire logic [DATA_IDX_W-1:0] rd_idx_i,
   output logic      [WORD_W-1:0]     rd_data_o
);

   logic [WORD_W-1:0] entry [DATA_DEPTH];

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   for (genvar g = 0; g < DATA_DEPTH; g++) begin : g_entry
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            entry[g] <= DATA_RESET;
         end else if (wr_en_i && (wr_idx_i == DATA_IDX_W'(g))) begin
            entry[g] <= wr_data_i;
         end
      end
   end

   assign rd_data_o = entry[rd_idx_i];

endmodule

`default_nettype wire

// ===== pc_paging_stack_indirect.sv
`default_nettype none

// Function
// - Increment past page end enters next page
// - Sequential increment leaves page bits untouched
// - Jump, call, low-byte write use page bits
// - Reset loads last address of last page
// - Reset clears page bits to page zero
// - Two stack levels, nine or eleven bits
// - Call shifts level one down, pushes counter+1
// - Deep calls silently keep two latest
// - Return pops level one, copies level two
// - Extra returns keep reusing level two
// - Return loads working register with literal
// - Stack holds full counter including page
// - Indirect location redirects through pointer
// - Indirect read with zero pointer gives 00h
// - Indirect write with zero pointer stores nothing
// - Pointer low five bits pick bank offset
// - Unbanked variant upper pointer bits read ones
// - Four-bank variant bit7 one, bits6:5 bank
// - Eight-bank variant bits7:5 select bank
// - Page codes map to 512-word pages
// - Jump supplies counter bits 8 to 0
// - Call or low-byte write clears bit 8
module pc_paging_stack_indirect
   import pc_paging_pkg::*;
#(
   parameter variant_e VARIANT = VARIANT_EIGHT_BANK
)(
   // Clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_n_i,
   // Avalon-MM slave
   input  wire logic [BUS_ADDR_W-1:0] avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [BUS_DATA_W-1:0] avs_writedata_i,
   input  wire logic [3:0]            avs_byteenable_i,
   output logic      [BUS_DATA_W-1:0] avs_readdata_o,
   output logic                       avs_waitrequest_o,
   // Instruction decoder
   input  wire op_e                   op_i,
   input  wire logic [OPERAND_W-1:0]  operand_i,
   // Core state
   output logic      [PC_W-1:0]       program_counter_o,
   output logic      [PC_W-1:0]       top_of_stack_o,
   output logic      [WORD_W-1:0]     working_reg_o
);

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_e;

   localparam logic [10:0] MASK = pc_mask(VARIANT);

   bus_state_e            bus_state;
   logic                  waitrequest;
   logic [BUS_DATA_W-1:0] readdata;

   logic [PC_W-1:0]       program_counter;
   logic [PC_W-1:0]       next_pc;
   logic [PC_W-1:0]       stack_level1;
   logic [PC_W-1:0]       stack_level2;
   logic [PC_W-1:0]       pc_plus_one;
   logic [PAGE_W-1:0]     page_select_bits;
   logic [PTR_W-1:0]      indirect_pointer;
   logic [WORD_W-1:0]     working_reg;

   logic                  sel_pointer;
   logic                  sel_indirect;
   logic                  sel_page;
   logic                  sel_data;
   logic [BUS_DATA_W-1:0] read_value;
   logic                  bus_wr;
   logic                  ind_live;
   logic [DATA_IDX_W-1:0] ind_idx;
   logic [DATA_IDX_W-1:0] win_idx;
   logic                  dm_wr_en;
   logic [DATA_IDX_W-1:0] dm_rd_idx;
   logic [WORD_W-1:0]     dm_rd_data;

   // ---------------------------------------------------------------
   // Indirect addressing
   // ---------------------------------------------------------------
   // Offset zero within a bank is the indirect location itself
   assign ind_live = (indirect_pointer[4:0] != OFFSET_ZERO);
   assign ind_idx  = pointer_index(VARIANT, indirect_pointer);
   assign win_idx  = avs_address_i[DATA_WIN_BIT-1:DATA_IDX_LSB];

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   always_comb begin
      sel_pointer  = 1'b0;
      sel_indirect = 1'b0;
      sel_page     = 1'b0;
      sel_data     = 1'b0;
      read_value   = '0;
      if (avs_address_i[DATA_WIN_BIT]) begin
         sel_data   = 1'b1;
         read_value = BUS_DATA_W'(dm_rd_data);
      end else if (avs_address_i == OFS_POINTER) begin
         sel_pointer = 1'b1;
         read_value  = BUS_DATA_W'(
            pointer_view(VARIANT, indirect_pointer));
      end else if (avs_address_i == OFS_INDIRECT) begin
         sel_indirect = 1'b1;
         read_value   = ind_live ? BUS_DATA_W'(dm_rd_data)
                                 : BUS_DATA_W'(INDIRECT_EMPTY);
      end else if (avs_address_i == OFS_PAGE) begin
         sel_page   = 1'b1;
         read_value = BUS_DATA_W'(page_select_bits);
      end else if (avs_address_i == OFS_PC) begin
         read_value = BUS_DATA_W'(program_counter);
      end else if (avs_address_i == OFS_LEVEL1) begin
         read_value = BUS_DATA_W'(stack_level1);
      end else if (avs_address_i == OFS_LEVEL2) begin
         read_value = BUS_DATA_W'(stack_level2);
      end else if (avs_address_i == OFS_WORK) begin
         read_value = BUS_DATA_W'(working_reg);
      end
   end

   // ---------------------------------------------------------------
   // Avalon handshake
   // ---------------------------------------------------------------
   // One wait cycle: read data is captured before it is presented
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_state   <= BUS_IDLE;
         waitrequest <= 1'b1;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_state   <= BUS_ACK;
                  waitrequest <= 1'b0;
               end
            end
            BUS_ACK: begin
               bus_state   <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default: begin
               bus_state   <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         readdata <= '0;
      end else if (bus_state == BUS_IDLE && avs_read_i) begin
         readdata <= read_value;
      end
   end

   assign avs_readdata_o    = readdata;
   assign avs_waitrequest_o = waitrequest;

   // Writes land on the edge where waitrequest is seen low
   assign bus_wr = (bus_state == BUS_ACK) && avs_write_i
                   && avs_byteenable_i[0];

   // ---------------------------------------------------------------
   // Software-written registers
   // ---------------------------------------------------------------
   // All eight bits are stored; unimplemented ones are forced on read
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         indirect_pointer <= POINTER_RESET;
      end else if (bus_wr && sel_pointer) begin
         indirect_pointer <= avs_writedata_i[PTR_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_select_bits <= PAGE_RESET;
      end else if (bus_wr && sel_page) begin
         page_select_bits <= avs_writedata_i[PAGE_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Data memory file
   // ---------------------------------------------------------------
   assign dm_wr_en  = bus_wr
                      && (sel_data || (sel_indirect && ind_live));
   assign dm_rd_idx = sel_data ? win_idx : ind_idx;

   data_file i_data_file (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .wr_en_i   (dm_wr_en),
      .wr_idx_i  (dm_rd_idx),
      .wr_data_i (avs_writedata_i[WORD_W-1:0]),
      .rd_idx_i  (dm_rd_idx),
      .rd_data_o (dm_rd_data)
   );

   // ---------------------------------------------------------------
   // Program counter
   // ---------------------------------------------------------------
   // Wrap is confined to the variant's width, so the page bits
   // roll over naturally on the last word of a page
   assign pc_plus_one = PC_W'(program_counter + 11'h001) & MASK;

   always_comb begin
      case (op_i)
         OP_STEP: begin
            next_pc = pc_plus_one;
         end
         OP_JUMP: begin
            next_pc = {page_select_bits, operand_i} & MASK;
         end
         OP_CALL, OP_WRITE_LOW: begin
            next_pc = {page_select_bits, 1'b0, operand_i[7:0]}
                      & MASK;
         end
         OP_RETURN: begin
            next_pc = stack_level1;
         end
         default: begin
            next_pc = program_counter;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         program_counter <= MASK;
      end else begin
         program_counter <= next_pc;
      end
   end

   // ---------------------------------------------------------------
   // Return stack
   // ---------------------------------------------------------------
   // No overflow or underflow flag: the oldest entry simply drops
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stack_level1 <= STACK_RESET;
         stack_level2 <= STACK_RESET;
      end else if (op_i == OP_CALL) begin
         stack_level2 <= stack_level1;
         stack_level1 <= pc_plus_one;
      end else if (op_i == OP_RETURN) begin
         stack_level1 <= stack_level2;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         working_reg <= WORK_RESET;
      end else if (op_i == OP_RETURN) begin
         working_reg <= operand_i[WORD_W-1:0];
      end
   end

   assign program_counter_o = program_counter;
   assign top_of_stack_o    = stack_level1;
   assign working_reg_o     = working_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic reset_seen;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reset_seen <= 1'b0;
      end else begin
         reset_seen <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking

   default disable iff (!rst_n_i);

   sequence s_call;
      op_i == OP_CALL;
   endsequence

   sequence s_return;
      op_i == OP_RETURN;
   endsequence

   sequence s_first_jump;
      !reset_seen && op_i == OP_JUMP;
   endsequence

   property p_reset_vector;
      !reset_seen |-> program_counter == MASK
                      && page_select_bits == PAGE_RESET;
   endproperty
   a_reset_vector: assert property (p_reset_vector)
      else $error("counter or page bits wrong after reset");

   property p_vector_jump;
      s_first_jump |=> program_counter[10:9] == 2'h0;
   endproperty
   a_vector_jump: assert property (p_vector_jump)
      else $error("jump at reset vector left page zero");

   property p_step_wrap;
      op_i == OP_STEP |=> program_counter
         == (PC_W'($past(program_counter) + 11'h001) & MASK);
   endproperty
   a_step_wrap: assert property (p_step_wrap)
      else $error("sequential step did not advance by one");

   property p_step_page;
      op_i == OP_STEP && !(bus_wr && sel_page) |=> $stable(page_select_bits);
   endproperty
   a_step_page: assert property (p_step_page)
      else $error("page bits changed on sequential step");

   property p_jump_target;
      op_i == OP_JUMP |=> program_counter
         == ({$past(page_select_bits), $past(operand_i)} & MASK);
   endproperty
   a_jump_target: assert property (p_jump_target)
      else $error("jump target not built from page bits");

   property p_call_low;
      op_i == OP_CALL || op_i == OP_WRITE_LOW |=> !program_counter[8];
   endproperty
   a_call_low: assert property (p_call_low)
      else $error("bit 8 not cleared by call or low write");

   property p_call_push;
      s_call |=> stack_level2 == $past(stack_level1)
         && stack_level1 == (PC_W'($past(program_counter) + 11'h001) & MASK);
   endproperty
   a_call_push: assert property (p_call_push)
      else $error("call did not push level one and counter");

   property p_call_chain;
      s_call ##1 s_call |=> stack_level2
         == (PC_W'($past(program_counter, 2) + 11'h001) & MASK);
   endproperty
   a_call_chain: assert property (p_call_chain)
      else $error("nested calls lost the newest two entries");

   property p_return_pop;
      s_return |=> program_counter == $past(stack_level1)
         && stack_level1 == $past(stack_level2);
   endproperty
   a_return_pop: assert property (p_return_pop)
      else $error("return did not pop level one");

   property p_return_repeat;
      s_return ##1 s_return |=> program_counter == $past(stack_level2, 2)
         && stack_level2 == $past(stack_level2, 2);
   endproperty
   a_return_repeat: assert property (p_return_repeat)
      else $error("second return did not reuse level two");

   property p_return_literal;
      s_return |=> working_reg == $past(operand_i[WORD_W-1:0]);
   endproperty
   a_return_literal: assert property (p_return_literal)
      else $error("return did not load working register");

   property p_indirect_zero;
      bus_state == BUS_IDLE && avs_read_i && sel_indirect && !ind_live
         |=> avs_readdata_o == BUS_DATA_W'(INDIRECT_EMPTY);
   endproperty
   a_indirect_zero: assert property (p_indirect_zero)
      else $error("indirect read with zero pointer not zero");

   property p_indirect_guard;
      bus_wr && sel_indirect && !ind_live
         |=> $stable(i_data_file.entry[ind_idx]);
   endproperty
   a_indirect_guard: assert property (p_indirect_guard)
      else $error("indirect write with zero pointer stored data");

   property p_pointer_ones;
      bus_state == BUS_IDLE && avs_read_i && sel_pointer
         |=> (VARIANT == VARIANT_EIGHT_BANK || avs_readdata_o[7])
         && (VARIANT != VARIANT_SINGLE_PAGE
             || avs_readdata_o[7:5] == 3'h7);
   endproperty
   a_pointer_ones: assert property (p_pointer_ones)
      else $error("unimplemented pointer bits not read as ones");

endmodule

`default_nettype wire

// ===== pc_paging_stack_indirect_bench.sv
`default_nettype none

module pc_paging_stack_indirect_bench
   import pc_paging_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                  ref_clk_i;
   logic                  rst_n_i;
   logic [BUS_ADDR_W-1:0] avs_address_i;
   logic                  avs_read_i;
   logic                  avs_write_i;
   logic [BUS_DATA_W-1:0] avs_writedata_i;
   logic [3:0]            avs_byteenable_i;
   logic [BUS_DATA_W-1:0] avs_readdata_o;
   logic                  avs_waitrequest_o;
   op_e                   op_i;
   logic [OPERAND_W-1:0]  operand_i;
   logic [PC_W-1:0]       program_counter_o;
   logic [PC_W-1:0]       top_of_stack_o;
   logic [WORD_W-1:0]     working_reg_o;
   logic [BUS_DATA_W-1:0] single_rdata;
   logic [PC_W-1:0]       single_pc;
   logic [BUS_DATA_W-1:0] four_rdata;
   int                    miscompares;
   int                    comparisons;
   logic [7:0]            ptrs [4] = '{8'h08, 8'h09, 8'h48, 8'he1};
   logic [7:0]            vals [4] = '{8'h10, 8'h0a, 8'h77, 8'hc3};
   logic [7:0]            zptr [2] = '{8'h00, 8'h40};

   pc_paging_stack_indirect #(
      .VARIANT(VARIANT_EIGHT_BANK)
   ) i_pc_paging_stack_indirect (
      .ref_clk_i         (ref_clk_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .op_i              (op_i),
      .operand_i         (operand_i),
      .program_counter_o (program_counter_o),
      .top_of_stack_o    (top_of_stack_o),
      .working_reg_o     (working_reg_o)
   );

   // Narrower variants share every input; only their views are compared
   pc_paging_stack_indirect #(
      .VARIANT(VARIANT_SINGLE_PAGE)
   ) i_pc_paging_stack_indirect_single (
      .ref_clk_i         (ref_clk_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (single_rdata),
      .avs_waitrequest_o (),
      .op_i              (op_i),
      .operand_i         (operand_i),
      .program_counter_o (single_pc),
      .top_of_stack_o    (),
      .working_reg_o     ()
   );

   pc_paging_stack_indirect #(
      .VARIANT(VARIANT_FOUR_BANK)
   ) i_pc_paging_stack_indirect_four (
      .ref_clk_i         (ref_clk_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (four_rdata),
      .avs_waitrequest_o (),
      .op_i              (op_i),
      .operand_i         (operand_i),
      .program_counter_o (),
      .top_of_stack_o    (),
      .working_reg_o     ()
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low at an edge
   task automatic bus(input logic wr, input logic [10:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      @(posedge ref_clk_i);
      avs_address_i    <= a;
      avs_writedata_i  <= d;
      avs_byteenable_i <= be;
      avs_write_i      <= wr;
      avs_read_i       <= !wr;
      do begin
         @(posedge ref_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask

   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask

   task automatic rd_chk(input logic [10:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(q, exp);
   endtask

   // One decoder op, then outputs checked once settled
   task automatic op(input op_e o, input logic [8:0] v,
                     input logic [10:0] pc, input logic [10:0] top_of_stack);
      @(posedge ref_clk_i);
      op_i      <= o;
      operand_i <= v;
      @(posedge ref_clk_i);
      op_i <= OP_HOLD;
      #1;
      chk({21'h0, program_counter_o}, {21'h0, pc});
      chk({21'h0, top_of_stack_o}, {21'h0, top_of_stack});
   endtask

   // Same op on two consecutive edges, then outputs checked
   task automatic op_pair(input op_e o, input logic [8:0] v1,
                          input logic [8:0] v2, input logic [10:0] pc,
                          input logic [10:0] top_of_stack);
      @(posedge ref_clk_i);
      op_i      <= o;
      operand_i <= v1;
      @(posedge ref_clk_i);
      operand_i <= v2;
      @(posedge ref_clk_i);
      op_i <= OP_HOLD;
      #1;
      chk({21'h0, program_counter_o}, {21'h0, pc});
      chk({21'h0, top_of_stack_o}, {21'h0, top_of_stack});
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog, tests
   // ------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // Whole run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      miscompares++;
      close_out();
   end

   initial begin
      miscompares      = 0;
      comparisons      = 0;
      rst_n_i          = 1'b0;
      avs_address_i    = '0;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = '0;
      avs_byteenable_i = 4'h0;
      op_i             = OP_HOLD;
      operand_i        = '0;
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk({21'h0, program_counter_o}, 32'h7ff);
      chk({21'h0, single_pc}, 32'h1ff);
      rd_chk(OFS_PAGE, 32'h0);
      op(OP_JUMP, 9'h005, 11'h005, 11'h000);
      op(OP_JUMP, 9'h1ff, 11'h1ff, 11'h000);
      op(OP_STEP, 9'h000, 11'h200, 11'h000);
      rd_chk(OFS_PAGE, 32'h0);
      op(OP_JUMP, 9'h010, 11'h010, 11'h000);
      wr(OFS_PAGE, 32'h2);
      op(OP_JUMP, 9'h1ff, 11'h5ff, 11'h000);
      op(OP_WRITE_LOW, 9'h1ab, 11'h4ab, 11'h000);
      op(OP_CALL, 9'h023, 11'h423, 11'h4ac);
      op(OP_CALL, 9'h040, 11'h440, 11'h424);
      rd_chk(OFS_LEVEL2, 32'h4ac);
      op(OP_CALL, 9'h150, 11'h450, 11'h441);
      rd_chk(OFS_LEVEL2, 32'h424);
      rd_chk(OFS_LEVEL1, 32'h441);
      wr(OFS_PAGE, 32'h0);
      op(OP_RETURN, 9'h05a, 11'h441, 11'h424);
      chk({24'h0, working_reg_o}, 32'h5a);
      op(OP_RETURN, 9'h0a5, 11'h424, 11'h424);
      chk({24'h0, working_reg_o}, 32'ha5);
      rd_chk(OFS_LEVEL2, 32'h424);
      op(OP_RETURN, 9'h03c, 11'h424, 11'h424);
      rd_chk(OFS_WORK, 32'h3c);
      op_pair(OP_CALL, 9'h011, 9'h022, 11'h022, 11'h012);
      rd_chk(OFS_LEVEL2, 32'h425);
      op_pair(OP_RETURN, 9'h0aa, 9'h0bb, 11'h425, 11'h425);
      chk({24'h0, working_reg_o}, 32'hbb);
      // Indirect stores, then read back three ways
      for (int i = 0; i < 4; i++) begin
         wr(OFS_POINTER, {24'h0, ptrs[i]});
         wr(OFS_INDIRECT, {24'h0, vals[i]});
      end
      for (int i = 0; i < 4; i++) begin
         wr(OFS_POINTER, {24'h0, ptrs[i]});
         rd_chk(OFS_POINTER, {24'h0, ptrs[i]});
         chk(single_rdata, {24'h0, ptrs[i] | 8'he0});
         chk(four_rdata, {24'h0, ptrs[i] | 8'h80});
         rd_chk(OFS_INDIRECT, {24'h0, vals[i]});
         rd_chk({1'b1, ptrs[i], 2'b00}, {24'h0, vals[i]});
      end
      // Pointer at the indirect location itself, bank 0 and bank 2
      for (int i = 0; i < 2; i++) begin
         wr(OFS_POINTER, {24'h0, zptr[i]});
         wr(OFS_INDIRECT, 32'h55);
         rd_chk(OFS_INDIRECT, 32'h0);
         rd_chk({1'b1, zptr[i], 2'b00}, 32'h0);
      end
      rd_chk(11'h01c, 32'h0);
      begin
         logic [31:0] q;
         bus(1'b1, OFS_POINTER, 32'h13, 4'h0, q);
      end
      rd_chk(OFS_POINTER, 32'h40);
      // Reset in mid-run with a non-zero page selected
      wr(OFS_PAGE, 32'h3);
      op(OP_JUMP, 9'h011, 11'h611, 11'h425);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      // Jump is the very first op after release: it runs at the vector
      rst_n_i   <= 1'b1;
      op_i      <= OP_JUMP;
      operand_i <= 9'h0c0;
      #1;
      chk({21'h0, program_counter_o}, 32'h7ff);
      chk({21'h0, top_of_stack_o}, 32'h0);
      @(posedge ref_clk_i);
      op_i <= OP_HOLD;
      #1;
      chk({21'h0, program_counter_o}, 32'h0c0);
      chk({21'h0, top_of_stack_o}, 32'h0);
      rd_chk(OFS_PAGE, 32'h0);
      close_out();
   end

endmodule

`default_nettype wire
